// ===== core/eaar_resolver.v
// Egress ACL action resolver: interface map, profile select, up to two
// TCAM lookups, action decode, hit counters, policer stats, hit flag.
// Assumes an external TCAM answers match/action combinationally from the
// keys, and that queue system and rewriter share clock_in.
`timescale 1ns/1ns
`include "eaar_defines.vh"

// Operation
// - Action fields packed upward from bit zero
// - One action decoding for every key type
// - Single-shot flag copies next hitting frame
// - CPU copy overrules single-shot, copy all
// - Hit interrupt enable raises hit event
// - Forward selector decode, queue on redirect/copy
// - Port index chooses redirect/copy destination port
// - Mirror probe only with copy forwarding
// - CPU copy request uses CPU queue
// - Policer enable meters with policer index
// - Mark-only colours yellow, never drops
// - Rewriter command passed downstream
// - Counter index selects hit counter per lookup
// - Override applies action on terminated frames
// - Build keys, at most two lookups
// - No match uses default action
// - Hit statistics updated per lookup
// - Policers assigned, policer statistics kept
// - Interface map returns port, interface, group
// - Map gives key number, group, profile
// - Per-entry select port or interface number
// - Control key select and port-mask fields
// - Profile lookup enable gates key and match
// - Profile addresses port, interface, CPU ranges
module eaar_resolver #(
  parameter VIRTUAL_QUEUE_PORT_W = 8,            // Virtual queue port width
  parameter CNT_N   = 2048,         // Hit counters
  parameter POL_N   = 64,           // Policers
  parameter CNT_W   = 32            // Counter width
) (
  // Clock and reset
  input  wire                     clock_in,
  input  wire                     rst_in,
  // Register port
  input  wire [7:0]               reg_addr_in,
  input  wire [31:0]              reg_wdata_in,
  input  wire                     reg_wr_in,
  input  wire                     reg_rd_in,
  output reg  [31:0]              reg_rdata_out,
  // Frame from queue system
  input  wire                     frm_valid_in,
  input  wire [VIRTUAL_QUEUE_PORT_W-1:0]       frm_virtual_queue_port_in,
  input  wire                     frm_to_cpu_in,
  input  wire [2:0]               frm_cpu_dest_in,
  input  wire                     frm_terminated_in,
  // Key toward the TCAM, per lookup
  output wire [1:0]               key_valid_out,
  output wire [6:0]               key_if_num_out,
  output wire                     key_is_vif_out,
  output wire [7:0]               key_acl_group_out,
  output wire [7:0]               key_profile_out,
  output wire [5:0]               key_select_out,
  output wire [127:0]             key_egress_port_mask_field_out,
  output wire                     key_egress_port_mask_range_out,
  // TCAM answers, per lookup
  input  wire [1:0]               tcam_match_in,
  input  wire [2*`EAAR_W_ACTION-1:0] tcam_action_in,
  // Resolved result toward the frame rewriter
  output reg                      res_valid_out,
  output reg  [`EAAR_W_FWD-1:0]   res_forward_selector_out,
  output reg  [`EAAR_W_QUEUE-1:0] res_queue_out,
  output reg  [`EAAR_W_PORT-1:0]  res_port_out,
  output reg  [`EAAR_W_MIRR-1:0]  res_mirror_probe_select_out,
  output reg                      res_cpu_copy_out,
  output reg  [`EAAR_W_CPUQ-1:0]  res_cpu_queue_out,
  output reg                      res_policer_enable_out,
  output reg                      res_policer_mark_only_out,
  output reg  [`EAAR_W_POLI-1:0]  res_policer_index_out,
  output reg  [`EAAR_W_REW-1:0]   res_rewriter_command_out,
  // Hit event flag
  output wire                     hit_flag_out
);

  localparam VP_N   = 1 << VIRTUAL_QUEUE_PORT_W;           // Interface map depth
  localparam PROF_N = 138;                    // Profile entries
  localparam AW     = `EAAR_W_ACTION;
  localparam CIW    = `EAAR_W_CNT;

  // Interface map and profile memories
  reg [`EAAR_W_IM-1:0] ifmap_mem [0:VP_N-1];  // Port, interface, group, select
  reg [7:0]            prof_mem  [0:PROF_N-1];// Lookup enables plus key selects
  reg [CNT_W-1:0]      cnt_mem   [0:CNT_N-1]; // Hit counters
  reg [CNT_W-1:0]      pol_mem   [0:POL_N-1]; // Policer frame statistics
  reg                  once_mem  [0:CNT_N-1]; // Single-shot already fired, by counter
  reg [AW-1:0]         defact_q;              // Default action for no match
  reg                  hit_q;                 // Sticky hit event
  reg [CIW-1:0]        cnt_sel_q;             // Counter read pointer
  reg [5:0]            pol_sel_q;             // Policer read pointer
  reg [VIRTUAL_QUEUE_PORT_W-1:0]    ifmap_ptr_q;           // Unused; map writes take index from data high bits
  integer              i;

  // Field extractors, one decoder for all key types
  function [AW-1:0] eaar_pick;
    input          m;
    input [AW-1:0] a;
    input [AW-1:0] d;
    begin
      eaar_pick = m ? a : d; // Default action on miss
    end
  endfunction

  // Stage 1: interface map lookup
  wire [`EAAR_W_IM-1:0] im = ifmap_mem[frm_virtual_queue_port_in];
  wire                  use_vif = im[`EAAR_IM_USEVIF];
  wire [6:0]            im_port = im[`EAAR_IM_PORT +: 7];
  wire [6:0]            im_vif  = im[`EAAR_IM_VIF +: 7];
  // Profile address by range: port, interface, CPU
  wire [7:0] prof_addr = frm_to_cpu_in ? (`EAAR_PROF_CPU + {5'h00, frm_cpu_dest_in}) :
                         use_vif ? (`EAAR_PROF_VIF + {1'b0, im_vif}) : {1'b0, im_port};
  wire [7:0] prof = prof_mem[prof_addr];
  // Key number and group from map, profile is the profile address (CPU range for frames to CPU)
  assign key_if_num_out    = use_vif ? im_vif : im_port;
  assign key_is_vif_out    = use_vif;
  assign key_acl_group_out = im[`EAAR_IM_GRP +: 8];
  assign key_profile_out   = prof_addr;
  // Lookup enable gates key generation
  assign key_valid_out     = {2{frm_valid_in}} & prof[1:0];
  assign key_select_out    = prof[7:2]; // Three bits per lookup
  // One-hot egress port mask and range flag
  assign key_egress_port_mask_field_out = {121'h0, 7'h01} << im_port;
  assign key_egress_port_mask_range_out = use_vif;

  // Matches only count where the lookup ran
  wire          m0 = key_valid_out[0] & tcam_match_in[0];
  wire          m1 = key_valid_out[1] & tcam_match_in[1];
  wire [AW-1:0] a0 = eaar_pick(m0, tcam_action_in[0 +: AW], defact_q);
  wire [AW-1:0] a1 = eaar_pick(m1, tcam_action_in[AW +: AW], defact_q);
  // Second lookup wins where it hit, else first
  wire [AW-1:0] act = m1 ? a1 : a0;
  wire [CIW-1:0] c0 = a0[`EAAR_A_CNT +: CIW];
  wire [CIW-1:0] c1 = a1[`EAAR_A_CNT +: CIW];
  wire [CIW-1:0] ca = act[`EAAR_A_CNT +: CIW];
  // Frame terminated upstream is left alone unless override
  wire apply = frm_valid_in & (~frm_terminated_in | act[`EAAR_A_IGN]);
  wire [1:0] fwd = act[`EAAR_A_FWD +: `EAAR_W_FWD];
  wire redir_copy = (fwd == `EAAR_FWD_REDIR) | (fwd == `EAAR_FWD_COPY);
  // Single-shot fires once per counter index, CPU copy overrides it
  wire once_fire = act[`EAAR_A_ONCE] & ~once_mem[ca] & (m0 | m1);
  wire cpu_copy  = act[`EAAR_A_CPUC] | once_fire;
  wire any_hit   = (m0 & a0[`EAAR_A_INTR]) | (m1 & a1[`EAAR_A_INTR]);

  // Result register toward the rewriter
  always @(posedge clock_in) begin
    if (rst_in) begin
      res_valid_out               <= 1'b0;
      res_forward_selector_out    <= `EAAR_FWD_FORWARD;
      res_queue_out               <= {`EAAR_W_QUEUE{1'b0}};
      res_port_out                <= {`EAAR_W_PORT{1'b0}};
      res_mirror_probe_select_out <= {`EAAR_W_MIRR{1'b0}};
      res_cpu_copy_out            <= 1'b0;
      res_cpu_queue_out           <= {`EAAR_W_CPUQ{1'b0}};
      res_policer_enable_out      <= 1'b0;
      res_policer_mark_only_out   <= 1'b0;
      res_policer_index_out       <= {`EAAR_W_POLI{1'b0}};
      res_rewriter_command_out    <= `EAAR_REW_NONE;
    end else begin
      res_valid_out <= frm_valid_in;
      if (apply) begin
        // Decoded action fields
        res_forward_selector_out <= fwd;
        res_queue_out <= redir_copy ? act[`EAAR_A_QUEUE +: `EAAR_W_QUEUE] : {`EAAR_W_QUEUE{1'b0}};
        res_port_out  <= redir_copy ? act[`EAAR_A_PORT +: `EAAR_W_PORT] : {`EAAR_W_PORT{1'b0}};
        // Probe only for copy forwarding
        res_mirror_probe_select_out <= (fwd == `EAAR_FWD_COPY) ?
                                       act[`EAAR_A_MIRR +: `EAAR_W_MIRR] : {`EAAR_W_MIRR{1'b0}};
        res_cpu_copy_out          <= cpu_copy;
        res_cpu_queue_out         <= act[`EAAR_A_CPUQ +: `EAAR_W_CPUQ];
        res_policer_enable_out    <= act[`EAAR_A_POLE];
        res_policer_mark_only_out <= act[`EAAR_A_POLM];
        res_policer_index_out     <= act[`EAAR_A_POLI +: `EAAR_W_POLI];
        res_rewriter_command_out  <= act[`EAAR_A_REW +: `EAAR_W_REW];
      end else begin
        // Pass-through: plain forward, nothing added
        res_forward_selector_out    <= `EAAR_FWD_FORWARD;
        res_queue_out               <= {`EAAR_W_QUEUE{1'b0}};
        res_port_out                <= {`EAAR_W_PORT{1'b0}};
        res_mirror_probe_select_out <= {`EAAR_W_MIRR{1'b0}};
        res_cpu_copy_out            <= 1'b0;
        res_cpu_queue_out           <= {`EAAR_W_CPUQ{1'b0}};
        res_policer_enable_out      <= 1'b0;
        res_policer_mark_only_out   <= 1'b0;
        res_policer_index_out       <= {`EAAR_W_POLI{1'b0}};
        res_rewriter_command_out    <= `EAAR_REW_NONE;
      end
    end
  end

  // Statistics and single-shot memory; memories are not reset, software
  // clears them, trading reset cost for a software init step
  always @(posedge clock_in) begin
    // Per-lookup hit counters; same index in both adds two
    if (m0 & m1 & (c0 == c1)) begin
      cnt_mem[c0] <= cnt_mem[c0] + 2'h2;
    end else begin
      if (m0) begin
        cnt_mem[c0] <= cnt_mem[c0] + 1'b1;
      end
      if (m1) begin
        cnt_mem[c1] <= cnt_mem[c1] + 1'b1;
      end
    end
    // Policer statistics for metered frames
    if (apply & act[`EAAR_A_POLE]) begin
      pol_mem[act[`EAAR_A_POLI +: `EAAR_W_POLI]] <= pol_mem[act[`EAAR_A_POLI +: `EAAR_W_POLI]] + 1'b1;
    end
    // Single-shot consumed; rearmed by software write
    if (once_fire & apply) begin
      once_mem[ca] <= 1'b1;
    end else if (reg_wr_in && reg_addr_in == `EAAR_REG_ONCECLR) begin
      once_mem[reg_wdata_in[CIW-1:0]] <= 1'b0;
    end
    // Table writes
    if (reg_wr_in && reg_addr_in == `EAAR_REG_IFMAP) begin
      ifmap_mem[reg_wdata_in[24 +: VIRTUAL_QUEUE_PORT_W]] <= reg_wdata_in[`EAAR_W_IM-1:0];
    end
    if (reg_wr_in && reg_addr_in == `EAAR_REG_PROF && reg_wdata_in[15:8] <= `EAAR_PROF_LAST) begin
      prof_mem[reg_wdata_in[15:8]] <= reg_wdata_in[7:0];
    end
    // Clearing a counter by write to its value register
    if (reg_wr_in && reg_addr_in == `EAAR_REG_CNTVAL) begin
      cnt_mem[cnt_sel_q] <= {CNT_W{1'b0}};
    end
    if (reg_wr_in && reg_addr_in == `EAAR_REG_POLVAL) begin
      pol_mem[pol_sel_q] <= {CNT_W{1'b0}};
    end
  end

  // Control registers and the sticky hit flag
  always @(posedge clock_in) begin
    if (rst_in) begin
      defact_q    <= {AW{1'b0}};
      hit_q       <= 1'b0;
      cnt_sel_q   <= {CIW{1'b0}};
      pol_sel_q   <= 6'h00;
      ifmap_ptr_q <= {VIRTUAL_QUEUE_PORT_W{1'b0}};
    end else begin
      if (reg_wr_in) begin
        case (reg_addr_in)
          `EAAR_REG_DEFACT0: defact_q[31:0]    <= reg_wdata_in;
          `EAAR_REG_DEFACT1: defact_q[AW-1:32] <= reg_wdata_in[AW-33:0];
          `EAAR_REG_CNTSEL:  cnt_sel_q         <= reg_wdata_in[CIW-1:0];
          `EAAR_REG_POLSEL:  pol_sel_q         <= reg_wdata_in[5:0];
          default:           ifmap_ptr_q       <= ifmap_ptr_q;
        endcase
      end
      // Set beats write-one-to-clear
      if (any_hit) begin
        hit_q <= 1'b1;
      end else if (reg_wr_in && reg_addr_in == `EAAR_REG_IRQ && reg_wdata_in[0]) begin
        hit_q <= 1'b0;
      end
    end
  end
  assign hit_flag_out = hit_q;

  // Read data one cycle after the strobe, zero otherwise
  always @(posedge clock_in) begin
    if (rst_in) begin
      reg_rdata_out <= `EAAR_ZERO32;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `EAAR_REG_DEFACT0: reg_rdata_out <= defact_q[31:0];
        `EAAR_REG_DEFACT1: reg_rdata_out <= {8'h00, defact_q[AW-1:32]};
        `EAAR_REG_IRQ:     reg_rdata_out <= {31'h0, hit_q};
        `EAAR_REG_CNTSEL:  reg_rdata_out <= {21'h0, cnt_sel_q};
        `EAAR_REG_CNTVAL:  reg_rdata_out <= cnt_mem[cnt_sel_q];
        `EAAR_REG_POLSEL:  reg_rdata_out <= {26'h0, pol_sel_q};
        `EAAR_REG_POLVAL:  reg_rdata_out <= pol_mem[pol_sel_q];
        default:           reg_rdata_out <= `EAAR_ZERO32; // Unmapped reads zero
      endcase
    end else begin
      reg_rdata_out <= `EAAR_ZERO32;
    end
  end

  // Single-shot memory starts cleared in simulation; other memories start unknown
  initial begin
    for (i = 0; i < CNT_N; i = i + 1) begin
      once_mem[i] = 1'b0;
    end
  end

endmodule

// ===== core/eaar_defines.vh
// Constants for the egress ACL action resolver: action word layout,
// forward selector codes, profile address ranges and register offsets.
// Assumes inclusion by bare name from the design file.
`ifndef EAAR_DEFINES_VH
`define EAAR_DEFINES_VH
// Action word field positions (lsb) and widths
`define EAAR_A_ONCE      0
`define EAAR_A_INTR      1
`define EAAR_A_FWD       2
`define EAAR_W_FWD       2
`define EAAR_A_QUEUE     4
`define EAAR_W_QUEUE     16
`define EAAR_A_PORT      20
`define EAAR_W_PORT      7
`define EAAR_A_MIRR      27
`define EAAR_W_MIRR      2
`define EAAR_A_CPUC      29
`define EAAR_A_CPUQ      30
`define EAAR_W_CPUQ      3
`define EAAR_A_POLE      33
`define EAAR_A_POLM      34
`define EAAR_A_POLI      35
`define EAAR_W_POLI      6
`define EAAR_A_REW       41
`define EAAR_W_REW       3
`define EAAR_A_CNT       44
`define EAAR_W_CNT       11
`define EAAR_A_IGN       55
`define EAAR_W_ACTION    56
// Forward selector codes
`define EAAR_FWD_FORWARD 2'h0
`define EAAR_FWD_DISCARD 2'h1
`define EAAR_FWD_REDIR   2'h2
`define EAAR_FWD_COPY    2'h3
// Rewriter commands
`define EAAR_REW_NONE    3'h0
`define EAAR_REW_SWAP    3'h1
`define EAAR_REW_L2CP    3'h2
// Profile address bases
`define EAAR_PROF_VIF    8'h41
`define EAAR_PROF_CPU    8'h82
`define EAAR_PROF_LAST   8'h89
// Register offsets (word addresses on the plain port)
`define EAAR_REG_IFMAP   8'h00
`define EAAR_REG_PROF    8'h01
`define EAAR_REG_DEFACT0 8'h02
`define EAAR_REG_DEFACT1 8'h03
`define EAAR_REG_IRQ     8'h04
`define EAAR_REG_CNTSEL  8'h05
`define EAAR_REG_CNTVAL  8'h06
`define EAAR_REG_POLSEL  8'h07
`define EAAR_REG_POLVAL  8'h08
`define EAAR_REG_ONCECLR 8'h09
// Interface map entry layout
`define EAAR_IM_PORT     0
`define EAAR_IM_VIF      7
`define EAAR_IM_GRP      14
`define EAAR_IM_USEVIF   22
`define EAAR_W_IM        23
// Reset value of a 32-bit word
`define EAAR_ZERO32      32'h00000000
`endif

// ===== tb/eaar_assertions.sv
// Port-level checker for the egress ACL action resolver.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ns
module eaar_assertions (
  // Clock, reset, register port
  input wire logic         clock_in,
  input wire logic         rst_in,
  input wire logic [7:0]   reg_addr_in,
  input wire logic [31:0]  reg_wdata_in,
  input wire logic         reg_wr_in,
  input wire logic         reg_rd_in,
  input wire logic [31:0]  reg_rdata_out,
  // Frame, key and TCAM answer
  input wire logic         frm_valid_in,
  input wire logic         frm_terminated_in,
  input wire logic [1:0]   key_valid_out,
  input wire logic [127:0] key_egress_port_mask_field_out,
  input wire logic [1:0]   tcam_match_in,
  input wire logic [111:0] tcam_action_in,
  // Result
  input wire logic         res_valid_out,
  input wire logic [1:0]   res_forward_selector_out,
  input wire logic [15:0]  res_queue_out,
  input wire logic [6:0]   res_port_out,
  input wire logic [1:0]   res_mirror_probe_select_out,
  input wire logic         res_cpu_copy_out,
  input wire logic [2:0]   res_cpu_queue_out,
  input wire logic         res_policer_enable_out,
  input wire logic [5:0]   res_policer_index_out,
  input wire logic [2:0]   res_rewriter_command_out,
  input wire logic         hit_flag_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // Second lookup hit on a live frame; it wins over the first
  wire hit1 = frm_valid_in && key_valid_out[1] && tcam_match_in[1] && !frm_terminated_in;
  a_res_one_late: assert property (1 |=> res_valid_out == $past(frm_valid_in)) else $error("result pulse late");
  a_key_gated: assert property (!frm_valid_in |-> key_valid_out == 2'h0) else $error("key without frame");
  a_dest_forward: assert property (res_valid_out && !res_forward_selector_out[1] |->
    res_queue_out == 16'h0 && res_port_out == 7'h0) else $error("queue or port on plain forward");
  a_mirror_copy: assert property (res_mirror_probe_select_out != 2'h0 |-> res_forward_selector_out == 2'h3)
    else $error("mirror without copy");
  a_apply_fwd: assert property (hit1 |=> res_forward_selector_out == $past(tcam_action_in[59:58]) &&
    res_rewriter_command_out == $past(tcam_action_in[99:97])) else $error("forward or rewriter wrong");
  a_apply_pol: assert property (hit1 |=> res_policer_enable_out == $past(tcam_action_in[89]) &&
    res_policer_index_out == $past(tcam_action_in[96:91])) else $error("policer wrong");
  a_cpu_copy: assert property (hit1 && tcam_action_in[85] |=> res_cpu_copy_out &&
    res_cpu_queue_out == $past(tcam_action_in[88:86])) else $error("cpu copy wrong");
  a_term_zero: assert property (frm_valid_in && frm_terminated_in && key_valid_out[1] && tcam_match_in[1] &&
    !tcam_action_in[111] |=> res_forward_selector_out == 2'h0 && !res_cpu_copy_out) else $error("terminated frame acted");
  a_flag_set: assert property (frm_valid_in && key_valid_out[0] && tcam_match_in[0] && tcam_action_in[1] &&
    !frm_terminated_in |=> hit_flag_out) else $error("hit flag not set");
  a_flag_hold: assert property (hit_flag_out && !(reg_wr_in && reg_addr_in == 8'h04 && reg_wdata_in[0])
    |=> hit_flag_out) else $error("hit flag lost");
  a_rdata_idle: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0) else $error("read data without read");
  a_mask_hot: assert property (key_valid_out != 2'h0 |-> $onehot(key_egress_port_mask_field_out))
    else $error("port mask not one-hot");
  c_both_hit: cover property (frm_valid_in && key_valid_out == 2'h3 && tcam_match_in == 2'h3);
  c_copy: cover property (res_valid_out && res_forward_selector_out == 2'h3);
  c_flag: cover property ($rose(hit_flag_out));
endmodule

// ===== tb/eaar_tcam_model.sv
// TCAM stand-in: answers match and action in the key cycle.
// Assumes the bench chooses which lookups hit and with what action.
`timescale 1ns/1ns
module eaar_tcam_model (
  // Clock
  input  wire logic         clock_in,
  // Key side
  input  wire logic [1:0]   key_valid_in,
  // Bench choice
  input  wire logic [1:0]   want_in,
  input  wire logic [111:0] act_in,
  // Answer
  output logic [1:0]        tcam_match_out,
  output logic [111:0]      tcam_action_out
);
  logic tog_q; // Flips each cycle so idle action bits never look stable
  always @(posedge clock_in) begin
    tog_q <= (tog_q === 1'b1) ? 1'b0 : 1'b1;
  end
  // One action format for both lookups; no key means no answer
  always @* begin
    tcam_match_out = key_valid_in & want_in;
    tcam_action_out[55:0] = key_valid_in[0] ? act_in[55:0] : {28{tog_q, ~tog_q}};
    tcam_action_out[111:56] = key_valid_in[1] ? act_in[111:56] : {28{~tog_q, tog_q}};
  end
endmodule

// ===== tb/eaar_resolver_tb_top.sv
// Self-checking bench for the egress ACL action resolver.
// Assumes fixed latencies: read data and result one cycle after the request.
`timescale 1ns/1ns
module eaar_resolver_tb_top;
  logic clock_in, rst_in, rw, rr, fv, fc, ft;
  logic [7:0] ra, vp;
  logic [31:0] wd, rv, st, v0;
  logic [2:0] fd;
  logic [1:0] kv, mt, want;
  logic [111:0] act, ta;
  logic [6:0] kin;
  logic [7:0] kg, kp;
  logic [5:0] ks;
  logic kvif, kmr, flag, resv;
  logic [127:0] kmask;
  logic [1:0] rf, rm;
  logic [15:0] rq;
  logic [6:0] rp;
  logic [2:0] rcq, rrw;
  logic rcc, rpe, rpm;
  logic [5:0] rpi;
  logic [31:0] ksnap;
  logic [55:0] dflt, a0, a1;
  int n_mismatch, checks, i;
  wire [38:0] got = {rf, rq, rp, rm, rcc, rpe, rpm, rpi, rrw}; // Result fields in one word
  eaar_resolver eaar_resolver_inst (.clock_in, .rst_in, .reg_addr_in(ra), .reg_wdata_in(wd), .reg_wr_in(rw),
    .reg_rd_in(rr), .reg_rdata_out(rv), .frm_valid_in(fv), .frm_virtual_queue_port_in(vp), .frm_to_cpu_in(fc),
    .frm_cpu_dest_in(fd), .frm_terminated_in(ft), .key_valid_out(kv), .key_if_num_out(kin), .key_is_vif_out(kvif),
    .key_acl_group_out(kg), .key_profile_out(kp), .key_select_out(ks), .key_egress_port_mask_field_out(kmask),
    .key_egress_port_mask_range_out(kmr), .tcam_match_in(mt), .tcam_action_in(ta), .res_valid_out(resv),
    .res_forward_selector_out(rf), .res_queue_out(rq), .res_port_out(rp), .res_mirror_probe_select_out(rm),
    .res_cpu_copy_out(rcc), .res_cpu_queue_out(rcq), .res_policer_enable_out(rpe), .res_policer_mark_only_out(rpm),
    .res_policer_index_out(rpi), .res_rewriter_command_out(rrw), .hit_flag_out(flag));
  eaar_tcam_model eaar_tcam_model_inst (.clock_in, .key_valid_in(kv), .want_in(want), .act_in(act),
    .tcam_match_out(mt), .tcam_action_out(ta));
  // Clock, 10 ns period
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  // Fixed-seed xorshift
  function automatic logic [31:0] xs();
    st = st ^ (st << 13);
    st = st ^ (st >> 17);
    st = st ^ (st << 5);
    return st;
  endfunction
  // Action word from a few chosen fields, others fixed
  function automatic logic [55:0] mk(input [10:0] c, input [5:0] pi, input pe, cc, input [1:0] f, input it, on);
    return {1'b0, c, 3'h1, pi, 1'b0, pe, 3'h5, cc, 2'h0, 7'h0, 16'h0, f, it, on};
  endfunction
  // Expected result: lookup 1 wins, miss takes default
  function automatic logic [38:0] exp_res(input [55:0] x0, x1, d, input [1:0] m, input t);
    logic [55:0] w;
    w = m[1] ? x1 : (m[0] ? x0 : d);
    if (t && !w[55]) w = 56'h0;
    return {w[3:2], w[3] ? w[19:4] : 16'h0, w[3] ? w[26:20] : 7'h0, (w[3:2] == 2'h3) ? w[28:27] : 2'h0,
            w[29], w[33], w[34], w[40:35], w[43:41]};
  endfunction
  task automatic cmp(input logic [63:0] g, e);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input [7:0] a, input [31:0] d);
    @(posedge clock_in);
    rw <= 1'b1; ra <= a; wd <= d;
    @(posedge clock_in);
    rw <= 1'b0;
  endtask
  task automatic rd(input [7:0] a, output logic [31:0] d);
    @(posedge clock_in);
    rr <= 1'b1; ra <= a;
    @(posedge clock_in);
    rr <= 1'b0;
    #1 d = rv;
  endtask
  // One frame; key snapshot taken in the frame cycle
  task automatic frm(input [7:0] p, input [3:0] cpu, input [1:0] h, input [55:0] x0, x1, input t);
    @(posedge clock_in);
    fv <= 1'b1; vp <= p; {fc, fd} <= cpu; want <= h; act <= {x1, x0}; ft <= t;
    #1 ksnap = {kv, kvif, kin, kg, kp, ks};
    @(posedge clock_in);
    fv <= 1'b0;
    #1;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Hang guard
  initial begin
    #400000;
    n_mismatch++;
    test_done();
  end
  initial begin
    {rw, rr, fv, fc, ft, ra, vp, wd, fd, want, act} = '0;
    st = 32'd41; n_mismatch = 0; checks = 0;
    rst_in = 1'b1;
    repeat (6) @(posedge clock_in);
    rst_in <= 1'b0;
    rd(8'h04, v0); cmp(v0, 0);
    rd(8'hFF, v0); cmp(v0, 0);
    // Map and profiles: port entry, interface entry, CPU profile
    wr(8'h00, {8'h01, 2'b00, 8'h07, 7'h00, 7'h05});
    wr(8'h00, {8'h02, 2'b01, 8'h03, 7'h09, 7'h0C});
    wr(8'h01, {16'h0, 8'd5, 6'h2A, 2'h3});
    wr(8'h01, {16'h0, 8'd74, 6'h11, 2'h1});
    wr(8'h01, {16'h0, 8'd137, 6'h05, 2'h2});
    frm(8'h01, 4'h0, 2'h0, 0, 0, 0); cmp(ksnap, {2'h3, 1'b0, 7'h05, 8'h07, 8'd5, 6'h2A});
    frm(8'h02, 4'h0, 2'h0, 0, 0, 0); cmp(ksnap, {2'h1, 1'b1, 7'h09, 8'h03, 8'd74, 6'h11});
    frm(8'h01, 4'hF, 2'h0, 0, 0, 0); cmp(ksnap, {2'h2, 1'b0, 7'h05, 8'h07, 8'd137, 6'h05});
    $display("test keys done");
    // Hit flag raise, hold, clear
    wr(8'h04, 1);
    frm(8'h01, 4'h0, 2'h1, mk(0, 0, 0, 0, 0, 1, 0), 0, 0);
    rd(8'h04, v0); cmp(v0, 1);
    rd(8'h04, v0); cmp(v0, 1);
    wr(8'h04, 1);
    rd(8'h04, v0); cmp(v0, 0);
    $display("test flag done");
    // Single shot: once, suppressed, re-armed, then cpu copy overrules
    wr(8'h09, 5);
    for (i = 0; i < 5; i++) begin
      if (i == 2) wr(8'h09, 5);
      frm(8'h01, 4'h0, 2'h2, 0, mk(5, 0, 0, i >= 3, 0, 0, 1), 0);
      cmp(rcc, (5'b11101 >> i) & 1);
    end
    $display("test single shot done");
    // Two hits on one counter add two; policer stat adds one
    wr(8'h05, 5); wr(8'h06, 0);
    frm(8'h01, 4'h0, 2'h3, mk(5, 0, 0, 0, 0, 0, 0), mk(5, 0, 0, 0, 0, 0, 0), 0);
    rd(8'h06, v0); cmp(v0, 2);
    wr(8'h07, 3); rd(8'h08, v0);
    frm(8'h01, 4'h0, 2'h2, 0, mk(0, 3, 1, 0, 0, 0, 0), 0);
    rd(8'h08, rv); cmp(rv, v0 + 1);
    $display("test stats done");
    // Random actions, default action, termination override
    dflt = {xs(), xs()};
    dflt[0] = 1'b0;
    wr(8'h02, dflt[31:0]); wr(8'h03, {8'h0, dflt[55:32]});
    for (i = 0; i < 200; i++) begin
      a0 = {xs(), xs()}; a1 = {xs(), xs()};
      a0[0] = 1'b0; a1[0] = 1'b0;
      frm(8'h01, 4'h0, xs(), a0, a1, st[7]);
      cmp(got, exp_res(a0, a1, dflt, want, ft));
    end
    $display("test random done");
    test_done();
  end
endmodule
bind eaar_resolver eaar_assertions eaar_assertions_inst (.clock_in, .rst_in, .reg_addr_in, .reg_wdata_in,
  .reg_wr_in, .reg_rd_in, .reg_rdata_out, .frm_valid_in, .frm_terminated_in, .key_valid_out,
  .key_egress_port_mask_field_out, .tcam_match_in, .tcam_action_in, .res_valid_out, .res_forward_selector_out,
  .res_queue_out, .res_port_out, .res_mirror_probe_select_out, .res_cpu_copy_out, .res_cpu_queue_out,
  .res_policer_enable_out, .res_policer_index_out, .res_rewriter_command_out, .hit_flag_out);
